// ==== tx_clk_sel_pkg.sv ====
/*
  Package for the transmit input clock select block: select levels, lane
  count, character width, PLL multipliers and the packed carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tx_clk_sel_pkg;

  localparam int          NUM_LANES   = 4;
  localparam int          CHAR_W      = 10;
  localparam logic [4:0]  MULT_FULL   = 5'h0a;
  localparam logic [4:0]  MULT_HALF   = 5'h14;
  localparam int          SYNC_DEPTH  = 2;
  localparam int          RST_MIN_EDG = 2;
  localparam logic [1:0]  RST_CNT_MAX = 2'h3;

  // Three-level pin as seen through a window comparator pair
  typedef enum logic [1:0]
  {
    SEL_LOW,
    SEL_MID,
    SEL_HIGH
  } level_t;

  typedef struct packed
  {
    logic [CHAR_W-1:0] char_bits;
    logic              odd_parity;
  } lane_word_t;

endpackage : tx_clk_sel_pkg

// ==== tx_input_clock_select.sv ====
/*
  Transmit input clock select: captures four lanes of 10-bit characters with
  odd parity on the edge chosen by the three-level select, tracks phase-align
  hold/adjust and reports the PLL multiplier.
  Assumes all clock-like inputs are slow enough (125 ns period) to be
  oversampled by sys_clk; the three-level pin arrives as two comparator bits.
*/
`timescale 1ns/100ps
module tx_input_clock_select
  import tx_clk_sel_pkg::*;
#(
  parameter int LANES = NUM_LANES
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   sel_pulled_up,
  input  wire logic                   sel_pulled_down,
  input  wire logic                   reference_clock,
  input  wire logic [LANES-1:0]       per_lane_write_clock,
  input  wire logic                   pll_rate_select,
  input  wire logic                   phase_align_reset_n,
  input  wire lane_word_t [LANES-1:0] lane_in,
  output lane_word_t [LANES-1:0]      lane_out,
  output logic [LANES-1:0]            lane_out_valid,
  output logic [1:0]                  input_write_clock_select,
  output logic [4:0]                  pll_multiplier,
  output logic                        phase_locked,
  output logic                        invalid_mode
);

  // Select decode and lane A fan-out are written for four lanes only
  if (LANES != NUM_LANES)
  begin : g_lane_count_check
    $error("tx_input_clock_select supports exactly four lanes");
  end

  // Pin synchronisers: stage a is read only by stage b
  typedef struct packed
  {
    logic [LANES+4:0]        sa;
    logic [LANES+4:0]        sb;
    lane_word_t [LANES-1:0]  lane_sa;
    lane_word_t [LANES-1:0]  lane_sb;
    lane_word_t [LANES-1:0]  lane_prev;
    logic                    ref_prev;
    logic [LANES-1:0]        wclk_prev;
    logic [1:0]              rst_cnt;
    lane_word_t [LANES-1:0]  data;
    logic [LANES-1:0]        vld;
    logic [1:0]              sel;
    logic [4:0]              mult;
    logic                    locked;
    logic                    bad;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic             ref_s;
  logic [LANES-1:0] wclk_s;
  logic             rate_s;
  logic             prst_n_s;
  level_t           lvl;
  logic             ref_rise;
  logic             ref_fall;
  logic [LANES-1:0] wrise;
  logic [LANES-1:0] cap;
  logic             bypass;

  assign ref_s    = st_q.sb[0];
  assign wclk_s   = st_q.sb[LANES:1];
  assign rate_s   = st_q.sb[LANES+1];
  assign prst_n_s = st_q.sb[LANES+2];
  assign ref_rise = ref_s & ~st_q.ref_prev;
  assign ref_fall = ~ref_s & st_q.ref_prev;
  assign wrise    = wclk_s & ~st_q.wclk_prev;
  assign bypass   = (lvl == SEL_LOW) && !rate_s;

  // Floating pin: neither comparator trips, so middle
  always_comb
  begin
    case (st_q.sb[LANES+4:LANES+3])
      2'h1:    lvl = SEL_HIGH;
      2'h2:    lvl = SEL_LOW;
      default: lvl = SEL_MID;
    endcase
  end

  always_comb
  begin
    cap = '0;
    case (lvl)
      SEL_LOW:
        // Per-lane clocks never looked at here
        cap = {LANES{ref_rise | (rate_s & ref_fall)}};
      SEL_MID:
        cap = wrise;
      SEL_HIGH:
        cap = {LANES{wrise[0]}};
      default:
        cap = '0;
    endcase
  end

  always_comb
  begin
    st_d           = st_q;
    st_d.sa        = {sel_pulled_down, sel_pulled_up, phase_align_reset_n,
                      pll_rate_select, per_lane_write_clock, reference_clock};
    st_d.sb        = st_q.sa;
    // Lane words ride the same two stages; the third lines up with the
    // last sample before the edge, so the host may change data after it
    st_d.lane_sa   = lane_in;
    st_d.lane_sb   = st_q.lane_sa;
    st_d.lane_prev = st_q.lane_sb;
    st_d.ref_prev  = ref_s;
    st_d.wclk_prev = wclk_s;
    st_d.vld       = cap;
    for (int i = 0; i < LANES; i++)
    begin
      if (cap[i])
        st_d.data[i] = st_q.lane_prev[i];
    end
    st_d.sel  = lvl;
    st_d.mult = rate_s ? MULT_HALF : MULT_FULL;
    st_d.bad  = rate_s && (lvl != SEL_LOW);
    // Reset counted in reference rises in rst_cnt; locked drops on the first low sample, not gated by the count
    if (bypass)
    begin
      st_d.rst_cnt = '0;
      st_d.locked  = 1'b1;
    end
    else if (!prst_n_s)
    begin
      st_d.locked = 1'b0;
      if (ref_rise && st_q.rst_cnt != RST_CNT_MAX)
        st_d.rst_cnt = st_q.rst_cnt + 2'h1;
    end
    else
    begin
      st_d.rst_cnt = '0;
      st_d.locked  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign lane_out                 = st_q.data;
  assign lane_out_valid           = st_q.vld;
  assign input_write_clock_select = st_q.sel;
  assign pll_multiplier           = st_q.mult;
  assign phase_locked             = st_q.locked;
  assign invalid_mode             = st_q.bad;

  chk_mid_own_clock: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_MID) |=> (lane_out_valid == $past(wrise)))
    else $error("mid select capture mismatch");

  chk_high_lane_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_HIGH && wrise[0]) |=> (&lane_out_valid && lane_out == $past(st_q.lane_prev)))
    else $error("high select did not capture all lanes");

  chk_low_ignores_wclk: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_LOW && !ref_rise && !ref_fall) |=> (lane_out_valid == '0))
    else $error("low select captured without reference edge");

  chk_phase_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!bypass && !prst_n_s) |=> !phase_locked)
    else $error("phase locked while adjusting");

  chk_pll_mult: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rate_s |=> (pll_multiplier == MULT_HALF))
    else $error("multiplier not doubled in half rate");

  chk_half_rate_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_LOW && rate_s && ref_fall) |=> &lane_out_valid)
    else $error("falling reference edge not sampled");

  chk_float_mid: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q.sb[LANES+4:LANES+3] == 2'h0) |=> (input_write_clock_select == SEL_MID))
    else $error("floating select not middle");

  chk_low_ref_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_LOW && ref_rise) |=> (&lane_out_valid && lane_out == $past(st_q.lane_prev)))
    else $error("reference rise capture missed");

  chk_bypass_ignore: assert property (@(posedge sys_clk) disable iff (!reset_n)
    bypass |=> phase_locked)
    else $error("phase reset honoured in bypass");

  chk_high_other_clk: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_HIGH && !wrise[0]) |=> (lane_out_valid == '0))
    else $error("high select captured without lane A edge");

  chk_phase_fixed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!bypass && prst_n_s) |=> phase_locked)
    else $error("phase not held with reset high");

  chk_pll_mult_ten: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !rate_s |=> (pll_multiplier == MULT_FULL))
    else $error("multiplier not ten in full rate");

  chk_high_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q.sb[LANES+4:LANES+3] == 2'h1) |=> (input_write_clock_select == SEL_HIGH))
    else $error("select at supply not high");

  chk_low_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q.sb[LANES+4:LANES+3] == 2'h2) |=> (input_write_clock_select == SEL_LOW))
    else $error("select at ground not low");

  chk_low_no_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lvl == SEL_LOW && !rate_s && ref_fall) |=> (lane_out_valid == '0))
    else $error("falling reference edge sampled in full rate");

  for (genvar g = 0; g < LANES; g++)
  begin : g_chk_lane
    chk_mid_lane_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lvl == SEL_MID && wrise[g]) |=> (lane_out[g] == $past(st_q.lane_prev[g])))
      else $error("mid select captured wrong word");
  end

endmodule : tx_input_clock_select

// ==== tx_host_model.sv ====
/*
  Host model: reference clock and four lane write clocks.
  Assumes run is raised and dropped away from reference edges.
*/
`timescale 1ns/100ps
module tx_host_model (
  input  wire logic       run,
  output logic            reference_clock,
  output wire logic [3:0] per_lane_write_clock,
  output int              ref_rises
);
  // Stops low between runs so capture counts are exact
  initial
  begin
    reference_clock = 1'b0;
    ref_rises       = 0;
    forever
    begin
      wait (run);
      #62.5 reference_clock = 1'b1;
      ref_rises++;
      #62.5 reference_clock = 1'b0;
    end
  end
  // Same frequency, fixed phase offset per lane
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign #(10 + 15 * i) per_lane_write_clock[i] = reference_clock;
  end
endmodule : tx_host_model

// ==== tb_tx_input_clock_select.sv ====
/*
  Bench: host model makes clocks, bench drives selects and lane data.
  Assumes lane data held constant across each run.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_tx_input_clock_select;
  import tx_clk_sel_pkg::*;
  logic             sys_clk = 1'b0, reset_n = 1'b0, run = 1'b0;
  logic             up = 1'b0, down = 1'b1, rate = 1'b0, prst_n = 1'b1;
  lane_word_t [3:0] lane_in = '0;
  lane_word_t [3:0] lane_out;
  logic [3:0]       valid, lane_clk;
  logic [1:0]       sel;
  logic [4:0]       mult;
  logic             locked, bad_mode, ref_clk;
  int               errors = 0, cmp_count = 0, ref_rises, full;
  int               cnt[4];
  lane_word_t       exp_w;
  lane_word_t       exp_q[4][$];
  wire logic [1:0]  lvl_m = (up & ~down) ? 2'h2 : ((down & ~up) ? 2'h0 : 2'h1);

  tx_host_model i_tx_host_model (.run(run), .reference_clock(ref_clk),
    .per_lane_write_clock(lane_clk), .ref_rises(ref_rises));
  tx_input_clock_select i_tx_input_clock_select (.sys_clk(sys_clk), .reset_n(reset_n),
    .sel_pulled_up(up), .sel_pulled_down(down), .reference_clock(ref_clk),
    .per_lane_write_clock(lane_clk), .pll_rate_select(rate),
    .phase_align_reset_n(prst_n), .lane_in(lane_in), .lane_out(lane_out),
    .lane_out_valid(valid), .input_write_clock_select(sel), .pll_multiplier(mult),
    .phase_locked(locked), .invalid_mode(bad_mode));

  always #5 sys_clk = ~sys_clk;

  // Bench model: words each lane should capture, in order
  always @(ref_clk)
  begin
    if (lvl_m == 2'h0 && (ref_clk || rate))
      for (int i = 0; i < 4; i++)
        exp_q[i].push_back(lane_in[i]);
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_model
    always @(posedge lane_clk[g])
    begin
      for (int i = 0; i < 4; i++)
        if ((lvl_m == 2'h1 && i == g) || (lvl_m == 2'h2 && g == 0))
          exp_q[i].push_back(lane_in[i]);
    end
  end

  // Sampled mid-cycle, where the one-cycle valid pulse is settled
  always @(negedge sys_clk)
  begin
    if (valid == 4'hf)
      full++;
    for (int i = 0; i < 4; i++)
      if (valid[i])
      begin
        cnt[i]++;
        exp_w = 'x;
        if (exp_q[i].size() > 0)
          exp_w = exp_q[i].pop_front();
        `CHK("lane_model", exp_w, lane_out[i])
        `CHK("lane_out", lane_in[i], lane_out[i])
      end
  end

  task automatic results();
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // f is edges per reference period; 0 skips counts in the invalid mode
  task automatic run_mode(input logic u, d, r, p, input logic [1:0] s, input int f);
    int r0;
    @(negedge sys_clk);
    {up, down, rate, prst_n} = {u, d, r, p};
    lane_in = 44'({$urandom, $urandom});
    cnt = '{default: 0};
    full = 0;
    r0 = ref_rises;
    repeat (8) @(negedge sys_clk);
    run = 1'b1;
    #2450;
    run = 1'b0;
    #300;
    `CHK("sel", s, sel)
    `CHK("mult", r ? MULT_HALF : MULT_FULL, mult)
    `CHK("locked", p | (s == 2'h0 & !r), locked)
    `CHK("invalid", r & (s != 2'h0), bad_mode)
    for (int i = 0; i < 4 && f > 0; i++)
      `CHK("captures", f * (ref_rises - r0), cnt[i])
    if (f > 0)
      `CHK("all_lanes", s == 2'h1 ? 0 : cnt[0], full)
    for (int i = 0; i < 4; i++)
      `CHK("queued", 0, exp_q[i].size())
  endtask : run_mode

  initial
  begin
    void'($urandom(12));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    run_mode(0, 1, 0, 0, 0, 1);
    run_mode(0, 1, 1, 0, 0, 2);
    run_mode(0, 0, 0, 0, 1, 1);
    run_mode(0, 0, 0, 1, 1, 1);
    run_mode(1, 0, 0, 1, 2, 1);
    run_mode(1, 0, 1, 1, 2, 0);
    results();
  end

  initial
  begin
    #200000;
    errors++;
    results();
  end
endmodule : tb_tx_input_clock_select
